// ### inc/rwl_pkg.sv
package rwl_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLOCK_FREQ_HZ      = 100_000_000;
    localparam int unsigned LAMP_HALF_PERIOD_MS = 500;
    localparam int unsigned LAMP_HALF_CYCLES   =
        LAMP_HALF_PERIOD_MS * (CLOCK_FREQ_HZ / 1000);

    // ************************************************************
    // register indices, byte address is four times the index
    // ************************************************************
    localparam logic [5:0] IDX_WD_UNIT      = 6'h11;
    localparam logic [5:0] IDX_WD_VALUE     = 6'h12;
    localparam logic [5:0] IDX_WD_CONTROL   = 6'h14;
    localparam logic [5:0] IDX_FIRST_LAMP   = 6'h15;
    localparam logic [5:0] IDX_SECOND_LAMP  = 6'h16;
    localparam logic [5:0] IDX_RESERVED     = 6'h17;
    localparam logic [5:0] IDX_MGMT_STATUS  = 6'h18;
    localparam logic [5:0] IDX_MGMT_ENABLE  = 6'h19;
    localparam logic [5:0] IDX_WAKE_STATUS  = 6'h1a;
    localparam logic [5:0] IDX_WAKE_ENABLE  = 6'h1b;
    localparam logic [5:0] IDX_GATE_CONTROL = 6'h1c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned WD_STATUS_BIT   = 0;
    localparam int unsigned WD_FORCE_BIT    = 2;
    localparam int unsigned WD_UNIT_BIT     = 7;
    localparam int unsigned MGMT_WD_BIT     = 0;
    localparam int unsigned MGMT_PORT3_BIT  = 1;
    localparam int unsigned MGMT_PORT4_BIT  = 2;
    localparam int unsigned GATE_WAKE_BIT   = 0;
    localparam int unsigned GATE_SERIAL_BIT = 6;
    localparam int unsigned GATE_PIN_BIT    = 7;
    localparam int unsigned WAKE_SOURCES    = 2;

    // ************************************************************
    // lamp codes and reset values
    // ************************************************************
    localparam logic [1:0] LAMP_OFF      = 2'h0;
    localparam logic [1:0] LAMP_FAST     = 2'h1;
    localparam logic [1:0] LAMP_SLOW     = 2'h2;
    localparam logic [1:0] LAMP_ON       = 2'h3;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] WD_DISABLED   = 8'h00;

endpackage

// ### rtl/rwl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rwl_regs
    import rwl_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYCLES = LAMP_HALF_CYCLES
)
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_clk_en,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic        i_watchdog_expired,
    input  wire logic        i_port_three_irq,
    input  wire logic        i_port_four_irq,
    input  wire logic        i_ring_indicate_three_n,
    input  wire logic        i_ring_indicate_four_n,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [7:0]       o_watchdog_timeout_value,
    output logic             o_watchdog_unit_select,
    output logic             o_watchdog_event,
    output logic             o_first_lamp,
    output logic             o_second_lamp,
    output logic             o_mgmt_irq_pin_n,
    output logic             o_mgmt_irq_serial,
    output logic             o_wake_request_out_n
);

    // ************************************************************
    // state
    // ************************************************************
    logic [1:0]                first_lamp_code;
    logic [1:0]                second_lamp_code;
    logic                      wd_status;
    logic                      mgmt_wd_status;
    logic [2:0]                mgmt_enable;
    logic [WAKE_SOURCES-1:0]   wake_status;
    logic [WAKE_SOURCES-1:0]   wake_enable;
    logic [WAKE_SOURCES-1:0]   ring_prev_n;
    logic                      global_wake_enable;
    logic                      serial_gate;
    logic                      pin_gate;
    logic [31:0]               tick_count;
    logic [1:0]                blink_phase;
    logic [5:0]                index;
    logic                      aligned;
    logic                      access;
    logic                      wr;
    logic                      force_hit;
    logic                      timeout_hit;
    logic                      wd_zeroing;
    logic [2:0]                mgmt_sources;
    logic [WAKE_SOURCES-1:0]   ring_now_n;
    logic [WAKE_SOURCES-1:0]   ring_event;
    logic [7:0]                next_rdata;
    logic                      next_mapped;

    assign index      = i_paddr[7:2];
    assign aligned    = (i_paddr[1:0] == 2'h0);
    assign access     = i_clk_en & i_psel & i_penable & o_pready;
    assign wr         = access & i_pwrite & aligned;
    assign ring_now_n = {i_ring_indicate_four_n, i_ring_indicate_three_n};

    function automatic logic hit(input logic [5:0] idx);
        hit = wr && (index == idx);
    endfunction

    function automatic logic lamp_level(input logic [1:0] code,
                                        input logic [1:0] phase);
        case (code)
            LAMP_OFF:  lamp_level = 1'b0;
            LAMP_FAST: lamp_level = ~phase[0];
            LAMP_SLOW: lamp_level = (phase == 2'h0);
            LAMP_ON:   lamp_level = 1'b1;
            default:   lamp_level = 1'b0;
        endcase
    endfunction

    // ************************************************************
    // apb slave: one wait state, answer registered
    // ************************************************************
    always_comb
    begin
        next_mapped = aligned;
        next_rdata  = RESET_BYTE;
        case (index)
            IDX_WD_UNIT:
                next_rdata[WD_UNIT_BIT] = o_watchdog_unit_select;
            IDX_WD_VALUE:     next_rdata = o_watchdog_timeout_value;
            IDX_WD_CONTROL:
                next_rdata[WD_STATUS_BIT] = wd_status;
            IDX_FIRST_LAMP:   next_rdata[1:0] = first_lamp_code;
            IDX_SECOND_LAMP:  next_rdata[1:0] = second_lamp_code;
            IDX_RESERVED:     next_rdata = RESET_BYTE;
            IDX_MGMT_STATUS:  next_rdata[2:0] = mgmt_sources;
            IDX_MGMT_ENABLE:  next_rdata[2:0] = mgmt_enable;
            IDX_WAKE_STATUS:
                next_rdata[WAKE_SOURCES-1:0] = wake_status;
            IDX_WAKE_ENABLE:
                next_rdata[WAKE_SOURCES-1:0] = wake_enable;
            IDX_GATE_CONTROL:
            begin
                next_rdata[GATE_WAKE_BIT]   = global_wake_enable;
                next_rdata[GATE_SERIAL_BIT] = serial_gate;
                next_rdata[GATE_PIN_BIT]    = pin_gate;
            end
            default:          next_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_pready <= i_psel & i_penable & ~o_pready;
            if (i_psel && i_penable && !o_pready)
            begin
                o_prdata  <= {24'h00_0000, next_rdata};
                o_pslverr <= ~next_mapped;
            end
        end
    end

    // ************************************************************
    // watchdog registers
    // ************************************************************
    assign force_hit   = hit(IDX_WD_CONTROL) & i_pwdata[WD_FORCE_BIT];
    assign timeout_hit = i_clk_en & (i_watchdog_expired | force_hit);
    assign wd_zeroing  = hit(IDX_WD_VALUE) &
                         (i_pwdata[7:0] == WD_DISABLED);

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_watchdog_timeout_value <= RESET_BYTE;
            o_watchdog_unit_select   <= 1'b0;
        end
        else
        begin
            if (hit(IDX_WD_VALUE))
                o_watchdog_timeout_value <= i_pwdata[7:0];
            if (hit(IDX_WD_UNIT))
                o_watchdog_unit_select <= i_pwdata[WD_UNIT_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            wd_status        <= 1'b0;
            o_watchdog_event <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_watchdog_event <= force_hit;
            if (wd_zeroing || o_watchdog_timeout_value == WD_DISABLED)
                wd_status <= 1'b0;
            else if (timeout_hit)
                wd_status <= 1'b1;
            else if (hit(IDX_WD_CONTROL) && !i_pwdata[WD_STATUS_BIT])
                wd_status <= 1'b0;
        end
    end

    // ************************************************************
    // management interrupt status and routing
    // ************************************************************
    assign mgmt_sources = {i_port_four_irq, i_port_three_irq,
                           mgmt_wd_status};

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            mgmt_wd_status <= 1'b0;
        else if (i_clk_en)
        begin
            if (timeout_hit && !wd_zeroing &&
                o_watchdog_timeout_value != WD_DISABLED)
                mgmt_wd_status <= 1'b1;
            else if (hit(IDX_MGMT_STATUS) && i_pwdata[MGMT_WD_BIT])
                mgmt_wd_status <= 1'b0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            mgmt_enable <= 3'h0;
            pin_gate    <= 1'b0;
            serial_gate <= 1'b0;
        end
        else
        begin
            if (hit(IDX_MGMT_ENABLE))
                mgmt_enable <= i_pwdata[2:0];
            if (hit(IDX_GATE_CONTROL))
            begin
                pin_gate    <= i_pwdata[GATE_PIN_BIT];
                serial_gate <= i_pwdata[GATE_SERIAL_BIT];
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_mgmt_irq_pin_n  <= 1'b1;
            o_mgmt_irq_serial <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_mgmt_irq_pin_n  <= ~(pin_gate &
                                   |(mgmt_sources & mgmt_enable));
            o_mgmt_irq_serial <= serial_gate &
                                 |(mgmt_sources & mgmt_enable);
        end
    end

    // ************************************************************
    // wake status, enables and request
    // ************************************************************
    assign ring_event = ring_prev_n & ~ring_now_n;

    generate
        for (genvar s = 0; s < WAKE_SOURCES; s++)
        begin : g_wake
            always_ff @(posedge i_clock)
            begin
                if (!i_rst_n)
                    wake_status[s] <= 1'b0;
                else if (i_clk_en)
                begin
                    if (ring_event[s])
                        wake_status[s] <= 1'b1;
                    else if (hit(IDX_WAKE_STATUS) && i_pwdata[s])
                        wake_status[s] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ring_prev_n        <= {WAKE_SOURCES{1'b1}};
            wake_enable        <= {WAKE_SOURCES{1'b0}};
            global_wake_enable <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ring_prev_n <= ring_now_n;
            if (hit(IDX_WAKE_ENABLE))
                wake_enable <= i_pwdata[WAKE_SOURCES-1:0];
            if (hit(IDX_GATE_CONTROL))
                global_wake_enable <= i_pwdata[GATE_WAKE_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_wake_request_out_n <= 1'b1;
        else if (i_clk_en)
            o_wake_request_out_n <= ~(global_wake_enable &
                                      |(wake_status & wake_enable));
    end

    // ************************************************************
    // lamp blink reference and outputs
    // ************************************************************
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            tick_count  <= 32'h0000_0000;
            blink_phase <= 2'h0;
        end
        else if (i_clk_en)
        begin
            if (tick_count == HALF_SEC_CYCLES - 1)
            begin
                tick_count  <= 32'h0000_0000;
                blink_phase <= blink_phase + 2'h1;
            end
            else
                tick_count <= tick_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            first_lamp_code  <= LAMP_OFF;
            second_lamp_code <= LAMP_OFF;
            o_first_lamp     <= 1'b0;
            o_second_lamp    <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (hit(IDX_FIRST_LAMP))
                first_lamp_code <= i_pwdata[1:0];
            if (hit(IDX_SECOND_LAMP))
                second_lamp_code <= i_pwdata[1:0];
            o_first_lamp  <= lamp_level(first_lamp_code, blink_phase);
            o_second_lamp <= lamp_level(second_lamp_code, blink_phase);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence

    sequence s_access;
        i_psel && i_penable && !o_pready;
    endsequence

    a_apb_one_wait: assert property (s_setup ##1 s_access |=> o_pready)
        else $error("apb answer not one cycle after access");

    a_wd_disabled_zero: assert property (
        o_watchdog_timeout_value == WD_DISABLED |=> !wd_status)
        else $error("watchdog status set while disabled");

    a_force_timeout: assert property (
        force_hit && o_watchdog_timeout_value != WD_DISABLED
        && !wd_zeroing |=> wd_status && mgmt_wd_status && o_watchdog_event)
        else $error("forced timeout not recorded");

    a_mgmt_wd_hold: assert property (
        mgmt_wd_status && !(hit(IDX_MGMT_STATUS) && i_pwdata[0])
        |=> mgmt_wd_status)
        else $error("watchdog management bit lost");

    a_reserved_zero: assert property (
        s_access and (index == IDX_RESERVED && !i_pwrite)
        |=> o_prdata == 32'h0000_0000)
        else $error("reserved register read not zero");

    a_lamp_steady: assert property (
        first_lamp_code == LAMP_ON |=> o_first_lamp)
        else $error("lamp code on not driving lamp");

    a_lamp_slow_off: assert property (
        second_lamp_code == LAMP_SLOW && blink_phase != 2'h0
        |=> !o_second_lamp)
        else $error("slow blink lamp on outside phase");

    a_ring_sets: assert property (
        ring_event[0] |=> wake_status[0])
        else $error("ring event not recorded");

    a_wake_request: assert property (
        global_wake_enable && |(wake_status & wake_enable)
        |=> !o_wake_request_out_n)
        else $error("wake request missing");

    a_wake_gated: assert property (
        !(|(wake_status & wake_enable)) |=> o_wake_request_out_n)
        else $error("wake request without enabled source");

    a_pin_gate: assert property (
        !pin_gate |=> o_mgmt_irq_pin_n)
        else $error("interrupt pin driven while gated off");

endmodule // rwl_regs
`default_nettype wire

// ### sim/rwl_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rwl_far_model
(
    input  wire logic i_clock,
    output logic      o_watchdog_expired,
    output logic      o_port_three_irq,
    output logic      o_port_four_irq,
    output logic      o_ring_three_n,
    output logic      o_ring_four_n
);
    // ************************************************************
    // pins beyond the block: counter, serial ports, ring inputs
    // ************************************************************
    // ring pins rest high on their pull-ups
    initial
    begin
        o_watchdog_expired = 1'b0;
        o_port_three_irq   = 1'b0;
        o_port_four_irq    = 1'b0;
        o_ring_three_n     = 1'b1;
        o_ring_four_n      = 1'b1;
    end
    // counter expiry is a single-cycle pulse
    task automatic expire();
        @(posedge i_clock);
        o_watchdog_expired <= 1'b1;
        @(posedge i_clock);
        o_watchdog_expired <= 1'b0;
    endtask
    // low pulse on one ring pin, whatever its pin function
    task automatic ring(input int which);
        @(posedge i_clock);
        if (which == 0)
            o_ring_three_n <= 1'b0;
        else
            o_ring_four_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        o_ring_three_n <= 1'b1;
        o_ring_four_n  <= 1'b1;
    endtask
    task automatic irq(input logic three, input logic four);
        @(posedge i_clock);
        o_port_three_irq <= three;
        o_port_four_irq  <= four;
    endtask
endmodule // rwl_far_model
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rwl_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int HALF = 8;
    logic        clock, rst_n, clk_en, psel, penable, pwrite;
    logic [7:0]  paddr, wd_value;
    logic [31:0] pwdata, prdata, rd_data;
    logic        pready, pslverr, rd_err, wd_unit, wd_event;
    logic        lamp1, lamp2, irq_pin_n, irq_serial, wake_n;
    logic        expired, irq3, irq4, ring3_n, ring4_n;
    int          bad_count = 0;
    int          n_compared = 0;
    int          ev_cnt = 0;

    rwl_regs #(.HALF_SEC_CYCLES(HALF)) rwl_regs_inst (
        .i_clock(clock), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata),
        .i_watchdog_expired(expired), .i_port_three_irq(irq3),
        .i_port_four_irq(irq4), .i_ring_indicate_three_n(ring3_n),
        .i_ring_indicate_four_n(ring4_n), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr),
        .o_watchdog_timeout_value(wd_value),
        .o_watchdog_unit_select(wd_unit), .o_watchdog_event(wd_event),
        .o_first_lamp(lamp1), .o_second_lamp(lamp2),
        .o_mgmt_irq_pin_n(irq_pin_n), .o_mgmt_irq_serial(irq_serial),
        .o_wake_request_out_n(wake_n));

    rwl_far_model rwl_far_model_inst (
        .i_clock(clock), .o_watchdog_expired(expired),
        .o_port_three_irq(irq3), .o_port_four_irq(irq4),
        .o_ring_three_n(ring3_n), .o_ring_four_n(ring4_n));

    always @(posedge clock)
        if (rst_n === 1'b1 && wd_event === 1'b1)
            ev_cnt <= ev_cnt + 1;

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 20)
        begin
            bad_count++;
            results();
        end
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let the write land before anyone looks at the outputs
        @(posedge clock);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp,
                      input logic err);
        apb(1'b0, idx, 8'h00);
        chk(rd_data, exp);
        chk1(rd_err, err);
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        logic [5:0] regs [10];
        regs = '{IDX_WD_UNIT, IDX_WD_VALUE, IDX_WD_CONTROL, IDX_FIRST_LAMP,
                 IDX_SECOND_LAMP, IDX_RESERVED, IDX_MGMT_STATUS,
                 IDX_MGMT_ENABLE, IDX_WAKE_STATUS, IDX_GATE_CONTROL};
        chk(32'({lamp1, lamp2, irq_pin_n, irq_serial, wake_n, wd_event}),
            32'h0a);
        foreach (regs[i])
            rd(regs[i], 32'h0, 1'b0);
        wr(IDX_RESERVED, 8'hff);
        rd(IDX_RESERVED, 32'h0, 1'b0);
        wr(6'h20, 8'hff);
        chk1(rd_err, 1'b1);
        rd(6'h20, 32'h0, 1'b1);
    endtask
    task automatic t_watchdog();
        int ev0;
        wr(IDX_MGMT_ENABLE, 8'h01);
        wr(IDX_GATE_CONTROL, 8'hc0);
        rwl_far_model_inst.expire();
        rd(IDX_WD_CONTROL, 32'h0, 1'b0);
        chk1(irq_pin_n, 1'b1);
        wr(IDX_WD_UNIT, 8'h80);
        wr(IDX_WD_VALUE, 8'hff);
        chk1(wd_unit, 1'b1);
        chk({24'h0, wd_value}, 32'hff);
        rd(IDX_WD_UNIT, 32'h80, 1'b0);
        rwl_far_model_inst.expire();
        rd(IDX_WD_CONTROL, 32'h1, 1'b0);
        rd(IDX_MGMT_STATUS, 32'h1, 1'b0);
        chk1(irq_pin_n, 1'b0);
        chk1(irq_serial, 1'b1);
        wr(IDX_GATE_CONTROL, 8'h00);
        settle();
        chk({30'h0, irq_pin_n, irq_serial}, 32'h2);
        wr(IDX_GATE_CONTROL, 8'hc0);
        wr(IDX_MGMT_ENABLE, 8'h00);
        settle();
        chk1(irq_pin_n, 1'b1);
        wr(IDX_MGMT_STATUS, 8'h00);
        rd(IDX_MGMT_STATUS, 32'h1, 1'b0);
        wr(IDX_MGMT_STATUS, 8'h01);
        rd(IDX_MGMT_STATUS, 32'h0, 1'b0);
        wr(IDX_WD_CONTROL, 8'h00);
        ev0 = ev_cnt;
        wr(IDX_WD_CONTROL, 8'h04);
        settle();
        chk(32'(ev_cnt - ev0), 32'h1);
        rd(IDX_WD_CONTROL, 32'h1, 1'b0);
        wr(IDX_WD_VALUE, 8'h00);
        rd(IDX_WD_CONTROL, 32'h0, 1'b0);
    endtask
    task automatic t_ports();
        wr(IDX_MGMT_STATUS, 8'h01);
        rwl_far_model_inst.irq(1'b1, 1'b0);
        rd(IDX_MGMT_STATUS, 32'h2, 1'b0);
        wr(IDX_MGMT_ENABLE, 8'h04);
        settle();
        chk1(irq_pin_n, 1'b1);
        wr(IDX_MGMT_ENABLE, 8'h02);
        settle();
        chk1(irq_pin_n, 1'b0);
        rwl_far_model_inst.irq(1'b0, 1'b1);
        rd(IDX_MGMT_STATUS, 32'h4, 1'b0);
        chk1(irq_pin_n, 1'b1);
        wr(IDX_MGMT_ENABLE, 8'h04);
        settle();
        chk1(irq_pin_n, 1'b0);
        rwl_far_model_inst.irq(1'b0, 1'b0);
    endtask
    task automatic t_lamps();
        int on_cnt;
        int exp_on [4];
        exp_on = '{0, 2 * HALF, HALF, 4 * HALF};
        wr(IDX_SECOND_LAMP, 8'hff);
        rd(IDX_SECOND_LAMP, 32'h3, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            wr(IDX_FIRST_LAMP, 8'(c));
            wr(IDX_SECOND_LAMP, 8'(c));
            settle();
            on_cnt = 0;
            repeat (4 * HALF)
            begin
                @(posedge clock);
                on_cnt += (lamp1 === 1'b1) ? 1 : 0;
                chk1(lamp2, lamp1);
            end
            chk(32'(on_cnt), 32'(exp_on[c]));
        end
    endtask
    task automatic t_wake();
        wr(IDX_WAKE_ENABLE, 8'hff);
        rd(IDX_WAKE_ENABLE, 32'h3, 1'b0);
        wr(IDX_WAKE_ENABLE, 8'h02);
        rwl_far_model_inst.ring(0);
        settle();
        rd(IDX_WAKE_STATUS, 32'h1, 1'b0);
        wr(IDX_GATE_CONTROL, 8'h01);
        chk1(wake_n, 1'b1);
        wr(IDX_WAKE_ENABLE, 8'h01);
        settle();
        chk1(wake_n, 1'b0);
        wr(IDX_GATE_CONTROL, 8'h00);
        settle();
        chk1(wake_n, 1'b1);
        wr(IDX_GATE_CONTROL, 8'h01);
        wr(IDX_WAKE_STATUS, 8'hfe);
        rd(IDX_WAKE_STATUS, 32'h1, 1'b0);
        chk1(wake_n, 1'b0);
        wr(IDX_WAKE_STATUS, 8'h01);
        rd(IDX_WAKE_STATUS, 32'h0, 1'b0);
        chk1(wake_n, 1'b1);
        rwl_far_model_inst.ring(1);
        settle();
        rd(IDX_WAKE_STATUS, 32'h2, 1'b0);
        wr(IDX_WAKE_STATUS, 8'h02);
        rd(IDX_WAKE_STATUS, 32'h0, 1'b0);
        // a ring pulse while the clock enable is low is never sampled
        clk_en <= 1'b0;
        rwl_far_model_inst.ring(0);
        clk_en <= 1'b1;
        settle();
        rd(IDX_WAKE_STATUS, 32'h0, 1'b0);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        rst_n   = 1'b0;
        clk_en  = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        $display("reset test done");
        t_watchdog();
        $display("watchdog test done");
        t_ports();
        $display("ports test done");
        t_lamps();
        $display("lamps test done");
        t_wake();
        $display("wake test done");
        results();
    end
endmodule // tb_top
`default_nettype wire
